// file: shared/selfprog_pkg.sv
// constants and types shared by the self-programming ends
package selfprog_pkg;
    // timing at the 40 MHz system clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_MIN_NS   = 3_700_000;
    localparam int PROG_MAX_NS   = 4_500_000;
    localparam int PROG_MIN_CYC  =
        (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYC  = PROG_MAX_NS / CLK_PERIOD_NS;
    localparam logic [2:0] LPM_WIN_CYC = 3'd3;
    localparam logic [2:0] SPM_WIN_CYC = 3'd4;

    // control register field positions and reset value
    localparam int BIT_INT_EN        = 7;
    localparam int BIT_RWW_BUSY      = 6;
    localparam int BIT_SIG_ROW_READ  = 5;
    localparam int BIT_RWW_RE        = 4;
    localparam int BIT_LOCKFUSE      = 3;
    localparam int BIT_PAGE_WR       = 2;
    localparam int BIT_PAGE_ER       = 1;
    localparam int BIT_STORE_PROG_EN = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_KEEP  = 8'hc0;

    // accepted low five bit patterns
    localparam logic [4:0] CMD_LOAD   = 5'h01;
    localparam logic [4:0] CMD_ERASE  = 5'h03;
    localparam logic [4:0] CMD_WRITE  = 5'h05;
    localparam logic [4:0] CMD_LOCK   = 5'h09;
    localparam logic [4:0] CMD_RWW_RE = 5'h11;

    // pointer values for fuse, lock and signature reads
    localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] Z_LOCK      = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam logic [15:0] Z_SIG0      = 16'h0000;
    localparam logic [15:0] Z_OSC_CAL   = 16'h0001;
    localparam logic [15:0] Z_SIG1      = 16'h0002;
    localparam logic [15:0] Z_SIG2      = 16'h0004;
    localparam logic [7:0]  SIG_RESERVED = 8'hff;

    // boot section sizes and reset addresses
    localparam logic [12:0] BOOT_WORDS_3 = 13'h0200;
    localparam logic [12:0] BOOT_WORDS_2 = 13'h0400;
    localparam logic [12:0] BOOT_WORDS_1 = 13'h0800;
    localparam logic [12:0] BOOT_WORDS_0 = 13'h1000;
    localparam logic [15:0] BOOT_ADDR_3  = 16'hfe00;
    localparam logic [15:0] BOOT_ADDR_2  = 16'hfc00;
    localparam logic [15:0] BOOT_ADDR_1  = 16'hf800;
    localparam logic [15:0] BOOT_ADDR_0  = 16'hf000;

    // controller register map over AHB-Lite
    localparam logic [7:0] REG_ZPTR   = 8'h00;
    localparam logic [7:0] REG_DATA   = 8'h04;
    localparam logic [7:0] REG_CTRL   = 8'h08;
    localparam logic [7:0] REG_ACTION = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int ACT_LPM_BIT     = 8;
    localparam int ACT_SPM_BIT     = 9;
    localparam int STAT_EE_BUSY    = 0;
    localparam int STAT_BLOCKED    = 1;
    localparam int STAT_LPM_DONE   = 2;
    localparam int STAT_FLASH_BUSY = 3;
    localparam logic       HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        OP_LOAD  = 2'b00,
        OP_ERASE = 2'b01,
        OP_WRITE = 2'b10,
        OP_LOCK  = 2'b11
    } flash_op_t;

    typedef enum logic {
        FL_IDLE = 1'b0,
        FL_BUSY = 1'b1
    } flash_state_t;
endpackage

// file: shared/selfprog_if.sv
// link between the cpu-side controller and the self-programming device
`timescale 1ns/1ps
interface selfprog_if;
    logic        ctrl_wr;
    logic [7:0]  ctrl_wdata;
    logic [7:0]  ctrl_rdata;
    logic        lpm_req;
    logic        spm_req;
    logic [15:0] zptr;
    logic [15:0] spm_data;
    logic        eeprom_write_busy;
    logic [7:0]  lpm_data;
    logic        lpm_valid;
    logic        flash_busy;

    modport dev
    (
        input  ctrl_wr,
        input  ctrl_wdata,
        input  lpm_req,
        input  spm_req,
        input  zptr,
        input  spm_data,
        input  eeprom_write_busy,
        output ctrl_rdata,
        output lpm_data,
        output lpm_valid,
        output flash_busy
    );

    modport cpu
    (
        output ctrl_wr,
        output ctrl_wdata,
        output lpm_req,
        output spm_req,
        output zptr,
        output spm_data,
        output eeprom_write_busy,
        input  ctrl_rdata,
        input  lpm_data,
        input  lpm_valid,
        input  flash_busy
    );
endinterface

// file: core/selfprog_dev.sv
// self-programming control register, read-out windows and flash timer
// Functional notes
// R01: eeprom write busy ignores flash programming writes
// R02: eeprom write busy also refuses fuse reads
// R03: software checks eeprom busy before control write
// R04: pointer 1 with lock select returns lock
// R05: lock select clears on read or timeout
// R06: cleared bits restore ordinary program memory load
// R07: pointer 0 with lock select returns low fuse
// R08: pointer 3 returns high fuse byte
// R09: pointer 2 returns extended fuse byte
// R10: programmed bits read zero, unprogrammed one
// R11: signature select load returns addressed signature
// R12: signature select clears on read or three cycles
// R13: pointers 0, 2, 4 give identification bytes
// R14: pointer 1 gives oscillator calibration byte
// R15: flash write finishes across a reset
// R16: timed flash operations last 3.7 to 4.5 ms
// R17: boot size code selects size and address
// R18: store enable allows store for four cycles
// R19: other low five bit patterns are ignored
// R20: store during signature read does nothing
// R21: fuse, lock, signature are static inputs
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module selfprog_dev
    import selfprog_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_MIN_CYC
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        por_b,
    input  wire logic        ce,
    selfprog_if.dev          bus,
    input  wire logic [7:0]  fuse_low_byte,
    input  wire logic [7:0]  fuse_high_byte,
    input  wire logic [7:0]  fuse_ext_byte,
    input  wire logic [7:0]  lock_bits,
    input  wire logic [7:0]  sig_byte0,
    input  wire logic [7:0]  sig_byte1,
    input  wire logic [7:0]  sig_byte2,
    input  wire logic [7:0]  osc_cal_byte,
    input  wire logic [1:0]  boot_size_sel,
    input  wire logic [7:0]  pm_rdata,
    output logic      [15:0] pm_addr,
    output logic             flash_op_start,
    output flash_op_t        flash_op,
    output logic      [15:0] flash_addr,
    output logic      [15:0] flash_wdata,
    output logic      [12:0] boot_words,
    output logic      [15:0] boot_reset_addr
);
    logic [7:0]   ctrl;
    logic [7:0]   next_ctrl;
    logic [2:0]   win_cnt;
    logic [2:0]   next_win;
    logic [17:0]  op_cnt;
    flash_state_t state;

    wire         busy;
    wire  [4:0]  cmd;
    wire         wr_take;
    wire         armed;
    wire         rd_lock;
    wire         rd_sig;
    wire         lpm_special;
    wire         spm_take;
    wire         timed;
    wire  [2:0]  win_limit;
    wire         expire;
    wire         op_done;
    wire  [7:0]  fuse_val;
    wire  [7:0]  sig_val;
    wire  [7:0]  lpm_val;

    function automatic logic cmd_ok(input logic [4:0] c);
        cmd_ok = (c == CMD_RWW_RE) || (c == CMD_LOCK) || (c == CMD_WRITE)
              || (c == CMD_ERASE) || (c == CMD_LOAD);
    endfunction

    function automatic flash_op_t op_of(input logic [4:0] c);
        case (c)
            CMD_ERASE: op_of = OP_ERASE;
            CMD_WRITE: op_of = OP_WRITE;
            CMD_LOCK:  op_of = OP_LOCK;
            default:   op_of = OP_LOAD;
        endcase
    endfunction

    function automatic logic [12:0] size_words(input logic [1:0] c);
        case (c)
            2'b11:   size_words = BOOT_WORDS_3;
            2'b10:   size_words = BOOT_WORDS_2;
            2'b01:   size_words = BOOT_WORDS_1;
            default: size_words = BOOT_WORDS_0;
        endcase
    endfunction

    function automatic logic [15:0] size_addr(input logic [1:0] c);
        case (c)
            2'b11:   size_addr = BOOT_ADDR_3;
            2'b10:   size_addr = BOOT_ADDR_2;
            2'b01:   size_addr = BOOT_ADDR_1;
            default: size_addr = BOOT_ADDR_0;
        endcase
    endfunction

    // command decode and access windows
    assign busy    = (state == FL_BUSY);
    assign cmd     = ctrl[4:0];
    assign wr_take = bus.ctrl_wr && !bus.eeprom_write_busy // R01 R02
                  && !busy && cmd_ok(bus.ctrl_wdata[4:0]); // R19
    assign armed   = ctrl[BIT_STORE_PROG_EN] && !busy;
    assign rd_lock = armed && (cmd == CMD_LOCK) && !ctrl[BIT_SIG_ROW_READ];
    assign rd_sig  = armed && ctrl[BIT_SIG_ROW_READ] && (cmd == CMD_LOAD);
    assign lpm_special = bus.lpm_req && (win_cnt < LPM_WIN_CYC)
                      && (rd_lock || rd_sig); // R04 R11
    assign spm_take = bus.spm_req && armed && (win_cnt < SPM_WIN_CYC) // R18
                   && !ctrl[BIT_SIG_ROW_READ]; // R20
    assign timed = spm_take && ((cmd == CMD_ERASE) || (cmd == CMD_WRITE)
                || (cmd == CMD_LOCK));
    assign win_limit = rd_sig ? LPM_WIN_CYC : SPM_WIN_CYC; // R12
    assign expire  = armed && (win_cnt == win_limit - 3'd1); // R05 R12
    assign op_done = busy && (op_cnt == 18'(PROG_CYCLES - 1)); // R16

    // read-out multiplexers over static inputs
    assign fuse_val = (bus.zptr == Z_LOCK)      ? lock_bits : // R04 R21
                      (bus.zptr == Z_FUSE_LOW)  ? fuse_low_byte : // R07
                      (bus.zptr == Z_FUSE_HIGH) ? fuse_high_byte : // R08
                      (bus.zptr == Z_FUSE_EXT)  ? fuse_ext_byte : // R09
                      pm_rdata;
    assign sig_val  = (bus.zptr == Z_SIG0)    ? sig_byte0 : // R13
                      (bus.zptr == Z_SIG1)    ? sig_byte1 :
                      (bus.zptr == Z_SIG2)    ? sig_byte2 :
                      (bus.zptr == Z_OSC_CAL) ? osc_cal_byte : // R14
                      SIG_RESERVED;
    // fuse and lock bits pass unchanged: programmed reads 0
    assign lpm_val = !lpm_special ? pm_rdata : // R06
                     rd_sig       ? sig_val  : fuse_val; // R10
    assign pm_addr = bus.zptr;

    assign bus.ctrl_rdata = {ctrl[7:1], ctrl[BIT_STORE_PROG_EN] | busy};
    assign bus.flash_busy = busy;

    // next control register value
    always_comb
    begin
        next_ctrl = ctrl;
        next_win  = win_cnt;
        if (op_done)
        begin
            next_ctrl = ctrl & CTRL_KEEP;
        end
        else if (wr_take)
        begin
            next_ctrl = {bus.ctrl_wdata[7], ctrl[BIT_RWW_BUSY],
                         bus.ctrl_wdata[5:0]};
            next_win  = 3'd0;
        end
        else if (armed)
        begin
            next_win = win_cnt + 3'd1;
            if (timed)
            begin
                next_ctrl[BIT_RWW_BUSY] = (cmd != CMD_LOCK);
            end
            else if (spm_take)
            begin
                next_ctrl = ctrl & CTRL_KEEP;
                next_ctrl[BIT_RWW_BUSY] = 1'b0;
            end
            else if (lpm_special || expire)
            begin
                next_ctrl = ctrl & CTRL_KEEP; // R05 R12
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl    <= CTRL_RESET;
            win_cnt <= 3'd0;
        end
        else if (ce)
        begin
            ctrl    <= next_ctrl;
            win_cnt <= next_win;
        end
    end

    // flash timer only power-on reset stops it
    always_ff @(posedge clk)
    begin
        if (!por_b)
        begin
            state  <= FL_IDLE;
            op_cnt <= 18'h0;
        end
        else if (ce)
        begin
            case (state)
                FL_IDLE:
                begin
                    op_cnt <= 18'h0;
                    if (timed && rst_b)
                        state <= FL_BUSY; // R15 R16
                end
                FL_BUSY:
                begin
                    op_cnt <= op_cnt + 18'h1;
                    if (op_done)
                        state <= FL_IDLE;
                end
                default: state <= FL_IDLE;
            endcase
        end
    end

    // load results and flash operation requests
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bus.lpm_valid   <= 1'b0;
            bus.lpm_data    <= 8'h00;
            flash_op_start  <= 1'b0;
            flash_op        <= OP_LOAD;
            flash_addr      <= 16'h0000;
            flash_wdata     <= 16'h0000;
            boot_words      <= BOOT_WORDS_0;
            boot_reset_addr <= BOOT_ADDR_0;
        end
        else if (ce)
        begin
            bus.lpm_valid   <= bus.lpm_req;
            flash_op_start  <= spm_take && (cmd != CMD_RWW_RE);
            boot_words      <= size_words(boot_size_sel); // R17
            boot_reset_addr <= size_addr(boot_size_sel); // R17
            if (bus.lpm_req)
                bus.lpm_data <= lpm_val;
            if (spm_take)
            begin
                flash_op    <= op_of(cmd);
                flash_addr  <= bus.zptr;
                flash_wdata <= bus.spm_data;
            end
        end
    end
endmodule

// file: core/selfprog_cpu.sv
// cpu-side controller: AHB-Lite registers driving the self-programming link
`timescale 1ns/1ps
module selfprog_cpu
    import selfprog_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        eeprom_write_busy,
    selfprog_if.cpu          bus
);
    logic       dp_valid;
    logic       dp_write;
    logic [7:0] dp_addr;
    logic       follow_lpm;
    logic       follow_spm;
    logic       blocked;
    logic       lpm_done;
    logic [7:0] lpm_last;

    wire        take;
    wire        wr_zptr;
    wire        wr_data;
    wire        wr_ctrl;
    wire        wr_act;
    wire        rd_stat;
    wire        ctrl_ok;
    wire [31:0] status;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    assign take    = hsel && hready && htrans[1] && (hsize == 3'h2);
    assign wr_zptr = dp_valid && dp_write && hit(dp_addr, REG_ZPTR);
    assign wr_data = dp_valid && dp_write && hit(dp_addr, REG_DATA);
    assign wr_ctrl = dp_valid && dp_write && hit(dp_addr, REG_CTRL);
    assign wr_act  = dp_valid && dp_write && hit(dp_addr, REG_ACTION);
    assign rd_stat = dp_valid && !dp_write && hit(dp_addr, REG_STATUS);
    assign ctrl_ok = wr_ctrl && !eeprom_write_busy; // R03
    assign status  = {28'h0, bus.flash_busy, lpm_done, blocked,
                      eeprom_write_busy};

    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign bus.eeprom_write_busy = eeprom_write_busy;
    assign hrdata = !dp_valid || dp_write    ? 32'h0 :
        hit(dp_addr, REG_ZPTR)   ? {16'h0, bus.zptr} :
        hit(dp_addr, REG_DATA)   ? {16'h0, bus.spm_data} :
        hit(dp_addr, REG_CTRL)   ? {24'h0, bus.ctrl_rdata} :
        hit(dp_addr, REG_ACTION) ? {24'h0, lpm_last} :
        hit(dp_addr, REG_STATUS) ? status : 32'h0;

    // address phase capture
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end
        else if (ce)
        begin
            dp_valid <= take;
            dp_write <= hwrite;
            dp_addr  <= haddr[7:0];
        end
    end

    // register writes and link strobes
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bus.zptr       <= 16'h0000;
            bus.spm_data   <= 16'h0000;
            bus.ctrl_wr    <= 1'b0;
            bus.ctrl_wdata <= 8'h00;
            bus.lpm_req    <= 1'b0;
            bus.spm_req    <= 1'b0;
            follow_lpm     <= 1'b0;
            follow_spm     <= 1'b0;
        end
        else if (ce)
        begin
            bus.ctrl_wr <= ctrl_ok;
            bus.lpm_req <= follow_lpm || (wr_act && hwdata[ACT_LPM_BIT]);
            bus.spm_req <= follow_spm || (wr_act && hwdata[ACT_SPM_BIT]);
            follow_lpm  <= ctrl_ok && hwdata[ACT_LPM_BIT];
            follow_spm  <= ctrl_ok && hwdata[ACT_SPM_BIT];
            if (wr_zptr)
                bus.zptr <= hwdata[15:0];
            if (wr_data)
                bus.spm_data <= hwdata[15:0];
            if (ctrl_ok)
                bus.ctrl_wdata <= hwdata[7:0];
        end
    end

    // sticky status, set wins over clear on read
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            blocked  <= 1'b0;
            lpm_done <= 1'b0;
            lpm_last <= 8'h00;
        end
        else if (ce)
        begin
            blocked  <= (wr_ctrl && eeprom_write_busy)
                     || (blocked && !rd_stat);
            lpm_done <= bus.lpm_valid || (lpm_done && !rd_stat);
            if (bus.lpm_valid)
                lpm_last <= bus.lpm_data;
        end
    end
endmodule

// file: test/selfprog_properties.sv
// concurrent checks on the self-programming link
`timescale 1ns/1ps
module selfprog_properties
    import selfprog_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_MIN_CYC
)
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_rdata,
    input wire logic       lpm_req,
    input wire logic       spm_req,
    input wire logic       eeprom_write_busy,
    input wire logic       lpm_valid,
    input wire logic       flash_busy
);
    int  busy_len = 0;
    wire ok_pat = ctrl_wdata[4:0] inside
        {CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_RWW_RE};
    wire start_ok = ctrl_wr && !flash_busy && !eeprom_write_busy;

    // length of the current busy stretch
    always_ff @(posedge clk)
        busy_len <= flash_busy ? busy_len + 1 : 0;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_busy_blocks: assert property (ctrl_wr && eeprom_write_busy
        && ctrl_rdata[5:0] == 6'h00 |=> ctrl_rdata[5:0] == 6'h00)
        else $error("control write taken while eeprom busy");
    chk_load_answer: assert property (lpm_req |=> lpm_valid)
        else $error("load not answered next cycle");
    chk_valid_cause: assert property (lpm_valid |-> $past(lpm_req))
        else $error("load data without a load");
    chk_lock_timeout: assert property (start_ok
        && ctrl_wdata[4:0] == 5'h09
        |=> ctrl_rdata[3:0] == 4'h9 ##[1:5]
            (ctrl_rdata[3:0] == 4'h0 || flash_busy))
        else $error("lock select did not clear");
    chk_sig_timeout: assert property (start_ok
        && ctrl_wdata[5:0] == 6'h21
        |=> ctrl_rdata[5] && ctrl_rdata[0] ##[1:4] ctrl_rdata[5:0] == 6'h00)
        else $error("signature select did not clear");
    chk_bad_pattern: assert property (start_ok && !ok_pat
        && ctrl_rdata[5:0] == 6'h00 |=> ctrl_rdata[5:0] == 6'h00)
        else $error("illegal pattern took effect");
    chk_special_clear: assert property (lpm_req
        && ctrl_rdata[3:0] == 4'h9 |=> ctrl_rdata[5:0] == 6'h00)
        else $error("mode bits kept after special load");
    chk_sig_no_store: assert property (spm_req && ctrl_rdata[5]
        && ctrl_rdata[0] && !flash_busy |=> !flash_busy)
        else $error("store in signature mode started flash");
    chk_prog_time: assert property ($fell(flash_busy)
        |-> busy_len == PROG_CYCLES)
        else $error("flash busy length wrong");
    chk_busy_holds: assert property (disable iff (1'b0)
        flash_busy && busy_len < PROG_CYCLES - 1 |=> flash_busy)
        else $error("flash timer stopped early");
endmodule

// file: test/flash_selfprog_config_readout_tb_top.sv
// self-checking bench for the cpu controller and device pair
`timescale 1ns/1ps
module flash_selfprog_config_readout_tb_top
    import selfprog_pkg::*;
;
    localparam int PC = 20;
    localparam logic [7:0] base [8] =
        '{8'h62, 8'hd9, 8'hfd, 8'hc3, 8'h1e, 8'h97, 8'h05, 8'h7a};
    localparam logic [7:0]  t_c [9] = '{8'h09, 8'h09, 8'h09, 8'h09,
        8'h21, 8'h21, 8'h21, 8'h21, 8'h21};
    localparam logic [15:0] t_z [9] = '{Z_LOCK, Z_FUSE_LOW, Z_FUSE_EXT,
        Z_FUSE_HIGH, Z_SIG0, Z_SIG1, Z_SIG2, Z_OSC_CAL, 16'h0006};
    localparam int t_i [9] = '{3, 0, 2, 1, 4, 5, 6, 7, 8};
    localparam logic [12:0] bw [4] =
        '{BOOT_WORDS_0, BOOT_WORDS_1, BOOT_WORDS_2, BOOT_WORDS_3};
    localparam logic [15:0] ba [4] =
        '{BOOT_ADDR_0, BOOT_ADDR_1, BOOT_ADDR_2, BOOT_ADDR_3};
    localparam logic [7:0] bad [4] = '{8'h07, 8'h0b, 8'h13, 8'h1f};

    logic        clk;
    logic        rst_b;
    logic        por_b;
    logic        hsel;
    logic        hwrite;
    logic        ee_busy;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [1:0]  boot_size_sel;
    logic [7:0]  cfg [8];
    logic [7:0]  msk;
    logic [7:0]  exp_b;
    flash_op_t   fop;
    wire  [15:0] faddr;
    wire  [15:0] fdata;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire  [7:0]  pm_rdata;
    wire  [15:0] pm_addr;
    wire  [12:0] boot_words;
    wire  [15:0] boot_reset_addr;
    int          err_total;
    int          tests_run;

    selfprog_if link();
    assign pm_rdata = pm_addr[7:0] ^ 8'h5a;

    selfprog_dev #(.PROG_CYCLES(PC)) u_selfprog_dev
    (
        .clk(clk), .rst_b(rst_b), .por_b(por_b), .ce(1'b1), .bus(link),
        .fuse_low_byte(cfg[0]), .fuse_high_byte(cfg[1]),
        .fuse_ext_byte(cfg[2]), .lock_bits(cfg[3]), .sig_byte0(cfg[4]),
        .sig_byte1(cfg[5]), .sig_byte2(cfg[6]), .osc_cal_byte(cfg[7]),
        .boot_size_sel(boot_size_sel), .pm_rdata(pm_rdata),
        .pm_addr(pm_addr), .flash_op_start(), .flash_op(fop),
        .flash_addr(faddr), .flash_wdata(fdata), .boot_words(boot_words),
        .boot_reset_addr(boot_reset_addr)
    );
    selfprog_cpu u_selfprog_cpu
    (
        .clk(clk), .rst_b(rst_b), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .eeprom_write_busy(ee_busy), .bus(link)
    );
    selfprog_properties #(.PROG_CYCLES(PC)) u_selfprog_properties
    (
        .clk(clk), .rst_b(rst_b), .ctrl_wr(link.ctrl_wr),
        .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata),
        .lpm_req(link.lpm_req), .spm_req(link.spm_req),
        .eeprom_write_busy(link.eeprom_write_busy),
        .lpm_valid(link.lpm_valid), .flash_busy(link.flash_busy)
    );

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // one single transfer, entered just after a rising edge
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, d, x);
    endtask

    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] e);
        logic [31:0] x;
        ahb(a, 1'b0, 32'h0, x);
        check(n, e, x);
    endtask

    task automatic lpm_read(input logic [7:0] c, input logic [15:0] z,
                            input logic [7:0] e, input logic [31:0] s);
        wr(REG_ZPTR, {16'h0, z});
        wr(REG_CTRL, {23'h0, 1'b1, c});
        repeat (4) @(posedge clk);
        rd("load data", REG_ACTION, {24'h0, e});
        rd("status", REG_STATUS, s);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 4 * PC && link.flash_busy !== 1'b0; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end

    initial
    begin
        {rst_b, por_b, hsel, hwrite, ee_busy} = '0;
        {haddr, hwdata, htrans, boot_size_sel} = '0;
        hsize = 3'h2;
        err_total = 0;
        tests_run = 0;
        cfg = base;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        rd("ctrl reset", REG_CTRL, 32'h0);
        rd("status reset", REG_STATUS, 32'h0);
        wr(8'h40, 32'h1);
        rd("unmapped", 8'h40, 32'h0);
        for (int p = 0; p < 2; p++)
        begin
            msk = p ? 8'hff : 8'h00;
            foreach (cfg[i]) cfg[i] <= base[i] ^ msk;
            for (int k = 0; k < 9; k++)
            begin
                exp_b = t_i[k] == 8 ? SIG_RESERVED : base[t_i[k]] ^ msk;
                lpm_read(t_c[k], t_z[k], exp_b, 32'h4);
            end
        end
        ee_busy <= 1'b1;
        @(posedge clk);
        lpm_read(8'h09, Z_LOCK, SIG_RESERVED, 32'h3);
        ee_busy <= 1'b0;
        @(posedge clk);
        rd("status idle", REG_STATUS, 32'h0);
        wr(REG_CTRL, 32'h109);
        ee_busy <= 1'b1;
        repeat (4) @(posedge clk);
        rd("late busy load", REG_ACTION, 32'h5b);
        rd("late busy ctrl", REG_CTRL, 32'h0);
        ee_busy <= 1'b0;
        wr(REG_ZPTR, 32'h5);
        wr(REG_CTRL, 32'h09);
        repeat (8) @(posedge clk);
        rd("lock timeout", REG_CTRL, 32'h0);
        wr(REG_ACTION, 32'h100);
        repeat (3) @(posedge clk);
        rd("plain load", REG_ACTION, 32'h5f);
        foreach (bad[i])
        begin
            wr(REG_CTRL, {24'h0, bad[i]});
            repeat (2) @(posedge clk);
            rd("bad pattern", REG_CTRL, 32'h0);
        end
        rd("status clear", REG_STATUS, 32'h4);
        wr(REG_CTRL, 32'h221);
        repeat (3) @(posedge clk);
        rd("sig store", REG_STATUS, 32'h0);
        wr(REG_DATA, 32'h1234);
        wr(REG_CTRL, 32'h203);
        repeat (2) @(posedge clk);
        rd("erase ctrl", REG_CTRL, 32'h43);
        rd("erase busy", REG_STATUS, 32'h8);
        check("erase op", {30'h0, OP_ERASE}, {30'h0, fop});
        check("erase at", 32'h5, {16'h0, faddr});
        check("erase data", 32'h1234, {16'h0, fdata});
        wait_idle();
        rd("erase done", REG_CTRL, 32'h40);
        wr(REG_CTRL, 32'h211);
        repeat (4) @(posedge clk);
        rd("rww enable", REG_CTRL, 32'h0);
        wr(REG_CTRL, 32'h205);
        repeat (3) @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd("reset ctrl", REG_CTRL, 32'h1);
        rd("reset busy", REG_STATUS, 32'h8);
        wait_idle();
        rd("write done", REG_STATUS, 32'h0);
        for (int b = 0; b < 4; b++)
        begin
            boot_size_sel <= b[1:0];
            repeat (2) @(posedge clk);
            check("boot words", {19'h0, bw[b]}, {19'h0, boot_words});
            check("boot at", {16'h0, ba[b]}, {16'h0, boot_reset_addr});
        end
        summarize();
    end
endmodule
